// >>> bench/temp_drift_compensation_cfg_tb.sv
/*
  self-checking bench for the drift compensation control block.
  assumes the plain register port and single-cycle measurement pulses.
*/
`timescale 1ns/10ps
module temp_drift_compensation_cfg_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [23:0] wdata = 24'h000000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic cycle_end = 1'b0;
  logic temp_done = 1'b0;
  logic [23:0] temp_ratio = 24'h000000;
  logic [23:0] rdata;
  logic temp_start;
  logic results_update;
  logic comp_active;
  logic sel_internal_temp;
  logic rspan_meas_en;
  logic rp_active;
  logic [23:0] rp_mult;
  logic [3:0] rp_int;
  logic [19:0] rp_frac;
  logic [23:0] gain_factor;
  logic [23:0] offset_factor;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  drift_comp_ctrl dut_u (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .cycle_end(cycle_end), .temp_start(temp_start),
    .temp_done(temp_done), .temp_ratio(temp_ratio), .results_update(results_update),
    .comp_active(comp_active), .sel_internal_temp(sel_internal_temp),
    .rspan_meas_en(rspan_meas_en), .rp_active(rp_active), .rp_mult(rp_mult),
    .rp_int(rp_int), .rp_frac(rp_frac), .gain_factor(gain_factor),
    .offset_factor(offset_factor)
  );

  always #4 clk = ~clk;

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      bad_count++;
      conclude();
    end
  end

  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [23:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask

  // one cycle_end pulse; start and update pulses checked in that cycle
  task automatic pulse_end(input logic exp_start, input logic exp_upd);
    @(posedge clk);
    cycle_end <= 1'b1;
    #1;
    chk("temp_start", temp_start, exp_start);
    chk("results_update", results_update, exp_upd);
    @(posedge clk);
    cycle_end <= 1'b0;
    #1;
  endtask

  task automatic applied(input logic en, input logic [23:0] g, input logic [23:0] o,
                         input logic rpa, input logic [23:0] rp);
    chk("comp_active", comp_active, en);
    chk("gain_factor", gain_factor, g);
    chk("offset_factor", offset_factor, o);
    chk("rp_active", rp_active, rpa);
    chk("rp_mult", rp_mult, rp);
    chk("rp_int", rp_int, rp[23:20]);
    chk("rp_frac", rp_frac, rp[19:0]);
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    reg_rd(8'h01, 24'h000000);
    reg_rd(8'h07, 24'h000000);
    reg_rd(8'h08, 24'h000000);
    reg_rd(8'h09, 24'h000000);
    $display("test reset values done");
    // settings, rspan source, rp enabled, negative multiple
    reg_wr(8'h08, 24'hc3a5f1);
    reg_wr(8'h09, 24'h5a0f3c);
    reg_wr(8'h07, 24'h81d41e);
    reg_wr(8'h01, 24'h000840);
    reg_wr(8'h10, 24'hffffff);
    reg_wr(8'h33, 24'h123456);
    reg_rd(8'h08, 24'hc3a5f1);
    reg_rd(8'h09, 24'h5a0f3c);
    reg_rd(8'h07, 24'h81d41e);
    reg_rd(8'h01, 24'h000840);
    reg_rd(8'h33, 24'h000000);
    applied(1'b0, 24'h000000, 24'h000000, 1'b0, 24'h000000);
    pulse_end(1'b0, 1'b1);
    applied(1'b1, 24'hc3a5f1, 24'h5a0f3c, 1'b1, 24'h81d41e);
    chk("rspan_meas_en", rspan_meas_en, 1'b1);
    chk("sel_internal_temp", sel_internal_temp, 1'b0);
    reg_rd(8'h10, 24'h000005);
    $display("test rspan source done");
    // internal source, rp off, stray pulses ignored before and while waiting
    reg_wr(8'h07, 24'h01d41e);
    reg_wr(8'h01, 24'h000140);
    @(posedge clk);
    temp_done <= 1'b1;
    temp_ratio <= 24'h0badc0;
    #1;
    chk("results_update", results_update, 1'b0);
    @(posedge clk);
    temp_done <= 1'b0;
    pulse_end(1'b1, 1'b0);
    reg_rd(8'h10, 24'h000007);
    pulse_end(1'b0, 1'b0);
    @(posedge clk);
    temp_done <= 1'b1;
    temp_ratio <= 24'h2a7e19;
    #1;
    chk("results_update", results_update, 1'b1);
    @(posedge clk);
    temp_done <= 1'b0;
    temp_ratio <= 24'h000000;
    #1;
    applied(1'b1, 24'hc3a5f1, 24'h5a0f3c, 1'b0, 24'h000000);
    chk("sel_internal_temp", sel_internal_temp, 1'b1);
    chk("rspan_meas_en", rspan_meas_en, 1'b0);
    reg_wr(8'hf5, 24'h111111);
    reg_rd(8'hf5, 24'h2a7e19);
    reg_rd(8'h10, 24'h000009);
    $display("test internal source done");
    // enable off: nothing applied
    reg_wr(8'h01, 24'h000800);
    pulse_end(1'b0, 1'b1);
    applied(1'b0, 24'h000000, 24'h000000, 1'b0, 24'h000000);
    chk("sel_internal_temp", sel_internal_temp, 1'b0);
    $display("test correction off done");
    conclude();
  end
endmodule

// >>> src/comp_settings_if.sv
/*
  carries software settings and the applied copy between the control block and
  its settings stage. assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
interface comp_settings_if;
  logic update;
  logic cfg_en;
  logic cfg_internal;
  logic cfg_rp_en;
  logic [drift_comp_pkg::DATA_W-1:0] cfg_rp;
  logic [drift_comp_pkg::DATA_W-1:0] cfg_gain;
  logic [drift_comp_pkg::DATA_W-1:0] cfg_offset;
  logic app_en;
  logic app_internal;
  logic app_rp_en;
  logic [drift_comp_pkg::DATA_W-1:0] app_rp;
  logic [drift_comp_pkg::DATA_W-1:0] app_gain;
  logic [drift_comp_pkg::DATA_W-1:0] app_offset;

  modport ctrl (
    output update, cfg_en, cfg_internal, cfg_rp_en, cfg_rp, cfg_gain, cfg_offset,
    input app_en, app_internal, app_rp_en, app_rp, app_gain, app_offset
  );
  modport stage (
    input update, cfg_en, cfg_internal, cfg_rp_en, cfg_rp, cfg_gain, cfg_offset,
    output app_en, app_internal, app_rp_en, app_rp, app_gain, app_offset
  );
endinterface

// >>> src/comp_settings_stage.sv
/*
  holds the settings that post-processing applies; takes a new copy only on update, at the
  end of a measurement cycle or after its internal temperature run. assumes update is a one-cycle pulse on clk.
*/
`timescale 1ns/10ps
module comp_settings_stage (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // settings
  comp_settings_if.stage s
);
  localparam logic [drift_comp_pkg::DATA_W-1:0] Z = drift_comp_pkg::DATA_ZERO;

  // disabled correction carries no factors at all
  wire logic [drift_comp_pkg::DATA_W-1:0] gain_next = s.cfg_en ? s.cfg_gain : Z;
  wire logic [drift_comp_pkg::DATA_W-1:0] offset_next = s.cfg_en ? s.cfg_offset : Z;
  wire logic rp_en_next = s.cfg_en & s.cfg_rp_en;
  wire logic [drift_comp_pkg::DATA_W-1:0] rp_next = rp_en_next ? s.cfg_rp : Z;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s.app_en <= 1'b0;
      s.app_internal <= 1'b0;
      s.app_rp_en <= 1'b0;
      s.app_rp <= Z;
      s.app_gain <= Z;
      s.app_offset <= Z;
    end
    else if (s.update)
    begin
      s.app_en <= s.cfg_en;
      s.app_internal <= s.cfg_internal;
      s.app_rp_en <= rp_en_next;
      s.app_rp <= rp_next;
      s.app_gain <= gain_next;
      s.app_offset <= offset_next;
    end
  end

  a_off_no_factors: assert property (@(posedge clk) disable iff (!nrst)
    !s.app_en |-> (s.app_gain == Z && s.app_offset == Z && !s.app_rp_en))
    else $error("factors applied while correction disabled");
  a_gain_load: assert property (@(posedge clk) disable iff (!nrst)
    s.update && s.cfg_en |=> s.app_gain == $past(s.cfg_gain))
    else $error("gain drift factor not taken at cycle end");
  a_offset_hold: assert property (@(posedge clk) disable iff (!nrst)
    !s.update |=> $stable(s.app_offset))
    else $error("offset drift factor changed outside cycle end");
  a_rp_gate: assert property (@(posedge clk) disable iff (!nrst)
    s.update && !s.cfg_rp_en |=> !s.app_rp_en && s.app_rp == Z)
    else $error("virtual resistor applied while not enabled");
endmodule

// >>> src/drift_comp_ctrl.sv
/*
  register file and cycle sequencing for load cell temperature drift correction.
  assumes the measurement engine runs on clk and drives cycle_end and temp_done
  as one-cycle pulses; software uses the plain register port.
*/
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module drift_comp_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // register port
  input wire logic [drift_comp_pkg::ADDR_W-1:0] addr,
  input wire logic [drift_comp_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [drift_comp_pkg::DATA_W-1:0] rdata,
  // measurement cycle
  input wire logic cycle_end,
  output logic temp_start,
  input wire logic temp_done,
  input wire logic [drift_comp_pkg::DATA_W-1:0] temp_ratio,
  output logic results_update,
  // applied correction
  output logic comp_active,
  output logic sel_internal_temp,
  output logic rspan_meas_en,
  output logic rp_active,
  output logic [drift_comp_pkg::DATA_W-1:0] rp_mult,
  output logic [drift_comp_pkg::RP_INT_BITS-1:0] rp_int,
  output logic [drift_comp_pkg::RP_FRAC_BITS-1:0] rp_frac,
  output logic [drift_comp_pkg::DATA_W-1:0] gain_factor,
  output logic [drift_comp_pkg::DATA_W-1:0] offset_factor
);
  logic [drift_comp_pkg::DATA_W-1:0] cfg_one_reg;
  logic [drift_comp_pkg::DATA_W-1:0] rp_reg;
  logic [drift_comp_pkg::DATA_W-1:0] gain_reg;
  logic [drift_comp_pkg::DATA_W-1:0] offset_reg;
  logic [drift_comp_pkg::DATA_W-1:0] ratio_reg;
  logic [drift_comp_pkg::DATA_W-1:0] rdata_reg;
  drift_comp_pkg::cycle_state_e state_reg;
  drift_comp_pkg::cycle_state_e state_next;

  comp_settings_if sif ();

  comp_settings_stage u_stage (
    .clk(clk),
    .nrst(nrst),
    .s(sif.stage)
  );

  // register decode
  wire logic hit_cfg = addr == drift_comp_pkg::IDX_MEAS_CFG_ONE;
  wire logic hit_rp = addr == drift_comp_pkg::IDX_VIRT_RP_MULT;
  wire logic hit_gain = addr == drift_comp_pkg::IDX_GAIN_DRIFT;
  wire logic hit_offset = addr == drift_comp_pkg::IDX_OFFSET_DRIFT;
  wire logic hit_status = addr == drift_comp_pkg::IDX_COMP_STATUS;
  wire logic hit_ratio = addr == drift_comp_pkg::IDX_TEMP_RATIO;

  wire logic want_en = cfg_one_reg[drift_comp_pkg::COMP_EN_BIT];
  wire logic want_internal = cfg_one_reg[drift_comp_pkg::SRC_INTERNAL_BIT];
  wire logic want_rp = cfg_one_reg[drift_comp_pkg::RP_EN_BIT];

  // status word
  logic [drift_comp_pkg::DATA_W-1:0] status_word;
  always_comb
  begin
    status_word = drift_comp_pkg::DATA_ZERO;
    status_word[drift_comp_pkg::ST_ACTIVE_BIT] = sif.app_en;
    status_word[drift_comp_pkg::ST_WAIT_BIT] = state_reg == drift_comp_pkg::ST_TEMP_WAIT;
    status_word[drift_comp_pkg::ST_RP_BIT] = sif.app_rp_en;
    status_word[drift_comp_pkg::ST_SRC_BIT] = sif.app_internal;
  end

  // unmapped indices read as zero
  wire logic [drift_comp_pkg::DATA_W-1:0] read_mux =
    hit_cfg ? cfg_one_reg :
    hit_rp ? rp_reg :
    hit_gain ? gain_reg :
    hit_offset ? offset_reg :
    hit_status ? status_word :
    hit_ratio ? ratio_reg : drift_comp_pkg::DATA_ZERO;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_one_reg <= drift_comp_pkg::CFG_ONE_RESET;
      rp_reg <= drift_comp_pkg::FACTOR_RESET;
      gain_reg <= drift_comp_pkg::FACTOR_RESET;
      offset_reg <= drift_comp_pkg::FACTOR_RESET;
    end
    else if (wr)
    begin
      if (hit_cfg)
        cfg_one_reg <= wdata;
      if (hit_rp)
        rp_reg <= wdata;
      if (hit_gain)
        gain_reg <= wdata;
      if (hit_offset)
        offset_reg <= wdata;
    end
  end

  // read data stand for one cycle only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rdata_reg <= drift_comp_pkg::DATA_ZERO;
    else
      rdata_reg <= rd ? read_mux : drift_comp_pkg::DATA_ZERO;
  end
  assign rdata = rdata_reg;

  // cycle end: one internal temperature run when enabled with internal source, then all results together
  wire logic need_temp = want_en & want_internal;
  wire logic temp_kick = cycle_end & need_temp & (state_reg == drift_comp_pkg::ST_IDLE);
  wire logic temp_fin = temp_done & (state_reg == drift_comp_pkg::ST_TEMP_WAIT);

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      drift_comp_pkg::ST_IDLE:
        if (temp_kick)
          state_next = drift_comp_pkg::ST_TEMP_WAIT;
      drift_comp_pkg::ST_TEMP_WAIT:
        if (temp_done)
          state_next = drift_comp_pkg::ST_IDLE;
      default:
        state_next = drift_comp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_reg <= drift_comp_pkg::ST_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ratio_reg <= drift_comp_pkg::DATA_ZERO;
    else if (temp_fin)
      ratio_reg <= temp_ratio;
  end

  assign temp_start = temp_kick;
  assign results_update = temp_fin |
    (cycle_end & !need_temp & (state_reg == drift_comp_pkg::ST_IDLE));

  // settings handed to the applied stage
  assign sif.update = results_update;
  assign sif.cfg_en = want_en;
  assign sif.cfg_internal = want_internal;
  assign sif.cfg_rp_en = want_rp;
  assign sif.cfg_rp = rp_reg;
  assign sif.cfg_gain = gain_reg;
  assign sif.cfg_offset = offset_reg;

  assign comp_active = sif.app_en;
  assign sel_internal_temp = sif.app_en & sif.app_internal;
  assign rspan_meas_en = sif.app_en & !sif.app_internal;
  assign rp_active = sif.app_rp_en;
  assign rp_mult = sif.app_rp;
  // signed 4.20: top bits integer part, rest fraction
  assign rp_int = sif.app_rp[drift_comp_pkg::DATA_W-1:drift_comp_pkg::RP_FRAC_BITS];
  assign rp_frac = sif.app_rp[drift_comp_pkg::RP_FRAC_BITS-1:0];
  assign gain_factor = sif.app_gain;
  assign offset_factor = sif.app_offset;

  sequence s_temp_fin;
    state_reg == drift_comp_pkg::ST_TEMP_WAIT && temp_done;
  endsequence
  sequence s_kick;
    cycle_end && need_temp && state_reg == drift_comp_pkg::ST_IDLE;
  endsequence

  a_enable_take: assert property (@(posedge clk) disable iff (!nrst)
    results_update |=> comp_active == $past(want_en))
    else $error("enable not applied at results update");
  a_source_take: assert property (@(posedge clk) disable iff (!nrst)
    results_update && want_en |=> sel_internal_temp == $past(want_internal))
    else $error("source select not applied");
  a_source_excl: assert property (@(posedge clk) disable iff (!nrst)
    !(sel_internal_temp && rspan_meas_en))
    else $error("both temperature sources selected");
  a_gain_out: assert property (@(posedge clk) disable iff (!nrst)
    results_update && want_en && !wr |=> gain_factor == gain_reg)
    else $error("gain factor output differs from register");
  a_rp_store: assert property (@(posedge clk) disable iff (!nrst)
    wr && hit_rp |=> rp_reg == $past(wdata))
    else $error("virtual resistor multiple not stored");
  a_rp_sign: assert property (@(posedge clk) disable iff (!nrst)
    rp_active |-> $signed(rp_int) == $signed(rp_mult) >>> drift_comp_pkg::RP_FRAC_BITS)
    else $error("virtual resistor integer part wrong");
  a_temp_once: assert property (@(posedge clk) disable iff (!nrst)
    s_kick |-> temp_start && !results_update ##1 !temp_start)
    else $error("temperature run not started once at cycle end");
  a_temp_result: assert property (@(posedge clk) disable iff (!nrst)
    s_temp_fin |-> results_update ##1 ratio_reg == $past(temp_ratio))
    else $error("ratio not updated with results");
  a_wait_ignore: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == drift_comp_pkg::ST_TEMP_WAIT && !temp_done |-> !results_update && !temp_start)
    else $error("results or new run while waiting for temperature");
  a_ratio_hold: assert property (@(posedge clk) disable iff (!nrst)
    !temp_fin |=> $stable(ratio_reg))
    else $error("ratio changed outside results update");
  a_read_slot: assert property (@(posedge clk) disable iff (!nrst)
    !rd |=> rdata == drift_comp_pkg::DATA_ZERO)
    else $error("read data outside read slot");
endmodule

// >>> src/drift_comp_pkg.sv
/*
  constants shared by the drift compensation control block and its settings stage.
  assumes an 8-bit register index and 24-bit register data.
*/
package drift_comp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;
  localparam int RP_FRAC_BITS = 20;
  localparam int RP_INT_BITS = DATA_W - RP_FRAC_BITS;

  // register indices
  localparam logic [ADDR_W-1:0] IDX_MEAS_CFG_ONE = 8'h01;
  localparam logic [ADDR_W-1:0] IDX_VIRT_RP_MULT = 8'h07;
  localparam logic [ADDR_W-1:0] IDX_GAIN_DRIFT = 8'h08;
  localparam logic [ADDR_W-1:0] IDX_OFFSET_DRIFT = 8'h09;
  localparam logic [ADDR_W-1:0] IDX_COMP_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] IDX_TEMP_RATIO = 8'hf5;

  // measurement_config_one fields
  localparam int COMP_EN_BIT = 6;
  localparam int SRC_INTERNAL_BIT = 8;
  localparam int RP_EN_BIT = 11;

  // comp status fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_WAIT_BIT = 1;
  localparam int ST_RP_BIT = 2;
  localparam int ST_SRC_BIT = 3;

  localparam logic [DATA_W-1:0] DATA_ZERO = 24'h000000;
  localparam logic [DATA_W-1:0] CFG_ONE_RESET = 24'h000000;
  localparam logic [DATA_W-1:0] FACTOR_RESET = 24'h000000;

  typedef enum logic [0:0] {ST_IDLE, ST_TEMP_WAIT} cycle_state_e;
endpackage
